// [rtl/scs_clk_div.sv]
/*
 holds a divide-by-2^n enable generator.
 assumes an enable pulse stream at its input and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module scs_clk_div (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick_in,
    input wire logic [1:0] log2_div,
    output logic tick_out
);
    logic [2:0] cnt;
    logic [2:0] mask;
    always_comb begin
        mask = 3'((4'h1 << log2_div) - 4'h1);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 3'h0;
        end else if (tick_in) begin
            cnt <= (cnt & mask) == mask ? 3'h0 : 3'(cnt + 3'h1);
        end
    end
    always_comb begin
        tick_out = tick_in && ((cnt & mask) == mask);
    end
endmodule

// [rtl/scs_pkg.sv]
/*
 holds constants and carriers for the system clock source control block.
 assumes a single 100 MHz clock and an 8-bit special function register port.
*/
package scs_pkg;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h8A;
    localparam logic [7:0] ADDR_INT_CAL = 8'h8B;
    localparam logic [7:0] ADDR_EXT_CTRL = 8'h8C;
    localparam logic [7:0] ADDR_CLK_SEL = 8'h8D;
    localparam logic [7:0] RST_INT_CTRL = 8'hC0;
    localparam logic [7:0] RST_EXT_CTRL = 8'h00;
    localparam logic [7:0] RST_CLK_SEL = 8'h00;
    // arbitrary neutral value, stands in for the factory trim
    localparam logic [7:0] RST_INT_CAL = 8'h80;
    localparam int BIT_INT_ON = 7;
    localparam int BIT_INT_RDY = 6;
    localparam int BIT_XTAL_VALID = 7;
    localparam int BIT_SRC = 0;
    localparam int CLK_MHZ = 100;
    // internal oscillator settle time in ns
    localparam int INT_SETTLE_NS = 100;
    localparam int INT_SETTLE_CYC = (INT_SETTLE_NS * CLK_MHZ + 999) / 1000;
    // crystal amplitude detection settle time in us
    localparam int XTAL_SETTLE_US = 500;
    localparam int XTAL_SETTLE_CYC = XTAL_SETTLE_US * CLK_MHZ;
    localparam logic [2:0] MODE_CMOS = 3'h2;
    localparam logic [2:0] MODE_CMOS_DIV2 = 3'h3;
    typedef struct packed {
        logic sel;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scs_bus_s;
endpackage

// [rtl/scs_top.sv]
/*
 holds the system clock source control: registers, oscillator status,
 prescaler and source selection as clock enables.
 assumes synchronous osc tick inputs and a single-cycle register port.
*/
// Function
// - reset selects the internal oscillator as system clock source
// - calibration byte read/write, resets to factory trim value
// - prescale code 00 div8, 01 div4, 10 div2, 11 div1
// - control bit 7 enables or disables the internal oscillator
// - ready bit reads 1 only when oscillator settled, writes ignored
// - enable (8A bit 7) and select (8D bit 0) internal oscillator take two writes
// - select bit 0: 0 internal prescaled, 1 external
// - external clock still delivered to peripherals when internal selected
// - crystal valid flag read-only, set when crystal stable in 11x
// - mode field bits 6-4 selects off, cmos, cmos/2, rc/2, xtal, xtal/2
// - frequency range bits 2-0 set crystal drive band
// - same bits select rc band or capacitor factor in rc modes
// - external control bit 3 reads zero, writes ignored
`timescale 1ns/1ps
module scs_top #(
    parameter int XTAL_SETTLE = scs_pkg::XTAL_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire scs_pkg::scs_bus_s bus,
    output logic [7:0] rdata,
    input wire logic int_osc_tick,
    input wire logic ext_osc_tick,
    output logic sysclk_en,
    output logic periph_ext_en,
    output logic int_osc_run,
    output logic [2:0] xosc_mode,
    output logic [2:0] xosc_range
);
    logic [7:0] int_ctrl;
    logic [7:0] int_cal;
    logic [6:0] ext_ctrl;
    logic src_bit;
    logic int_rdy;
    logic xtal_valid;
    logic [7:0] int_cnt;
    logic [31:0] xtal_cnt;
    logic ext_phase;
    logic ext_tick;
    logic int_div_tick;
    logic src_live;
    logic next_sys;
    logic wr_en;
    logic rd_en;
    logic hit_int_ctrl;
    logic hit_int_cal;
    logic hit_ext_ctrl;
    logic hit_clk_sel;
    assign wr_en = bus.sel && bus.wr;
    assign rd_en = bus.sel && !bus.wr;
    // register decode shared by the write paths
    always_comb begin
        hit_int_ctrl = 1'b0;
        hit_int_cal = 1'b0;
        hit_ext_ctrl = 1'b0;
        hit_clk_sel = 1'b0;
        if (bus.addr == scs_pkg::ADDR_INT_CTRL) begin
            hit_int_ctrl = 1'b1;
        end else if (bus.addr == scs_pkg::ADDR_INT_CAL) begin
            hit_int_cal = 1'b1;
        end else if (bus.addr == scs_pkg::ADDR_EXT_CTRL) begin
            hit_ext_ctrl = 1'b1;
        end else if (bus.addr == scs_pkg::ADDR_CLK_SEL) begin
            hit_clk_sel = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_ctrl <= scs_pkg::RST_INT_CTRL;
        end else if (wr_en && hit_int_ctrl) begin
            int_ctrl <= {bus.wdata[7], 5'h00, bus.wdata[1:0]};
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_cal <= scs_pkg::RST_INT_CAL;
        end else if (wr_en && hit_int_cal) begin
            int_cal <= bus.wdata;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_ctrl <= scs_pkg::RST_EXT_CTRL[6:0];
        end else if (wr_en && hit_ext_ctrl) begin
            ext_ctrl <= {bus.wdata[6:4], 1'b0, bus.wdata[2:0]};
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_bit <= scs_pkg::RST_CLK_SEL[0];
        end else if (wr_en && hit_clk_sel) begin
            src_bit <= bus.wdata[scs_pkg::BIT_SRC];
        end
    end
    // internal ready: settle count after enable or calibration change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_cnt <= 8'h00;
        end else if (!int_ctrl[scs_pkg::BIT_INT_ON] || (wr_en && hit_int_cal)) begin
            int_cnt <= 8'h00;
        end else if (!int_rdy) begin
            int_cnt <= 8'(int_cnt + 8'h01);
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_rdy <= 1'b1;
        end else if (!int_ctrl[scs_pkg::BIT_INT_ON] || (wr_en && hit_int_cal)) begin
            int_rdy <= 1'b0;
        end else if (!int_rdy) begin
            int_rdy <= int_cnt == 8'(scs_pkg::INT_SETTLE_CYC - 1);
        end
    end
    // crystal valid after settle in crystal modes only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xtal_cnt <= 32'h0;
        end else if (ext_ctrl[6:5] != 2'b11) begin
            xtal_cnt <= 32'h0;
        end else if (!xtal_valid && ext_osc_tick) begin
            xtal_cnt <= 32'(xtal_cnt + 32'h1);
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xtal_valid <= 1'b0;
        end else if (ext_ctrl[6:5] != 2'b11) begin
            xtal_valid <= 1'b0;
        end else if (!xtal_valid && ext_osc_tick) begin
            xtal_valid <= xtal_cnt >= 32'(XTAL_SETTLE - 1);
        end
    end
    // external divide-by-2 stage per mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_phase <= 1'b0;
        end else if (ext_ctrl[6:5] == 2'b00) begin
            ext_phase <= 1'b0;
        end else if (ext_osc_tick) begin
            ext_phase <= ~ext_phase;
        end
    end
    always_comb begin
        case (ext_ctrl[6:4])
            scs_pkg::MODE_CMOS, 3'h6: ext_tick = ext_osc_tick;
            scs_pkg::MODE_CMOS_DIV2, 3'h4, 3'h5, 3'h7: ext_tick = ext_osc_tick && ext_phase;
            default: ext_tick = 1'b0;
        endcase
    end
    scs_clk_div u_div (
        .clk(clk),
        .rst_n(rst_n),
        .tick_in(int_osc_tick && int_ctrl[scs_pkg::BIT_INT_ON]),
        .log2_div(2'(~int_ctrl[1:0])),
        .tick_out(int_div_tick)
    );
    // source change taken only between clock enables
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_live <= 1'b0;
        end else if (!int_div_tick && !ext_tick) begin
            src_live <= src_bit;
        end
    end
    always_comb begin
        next_sys = src_live ? ext_tick : int_div_tick;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sysclk_en <= 1'b0;
        end else begin
            sysclk_en <= next_sys;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_ext_en <= 1'b0;
        end else begin
            periph_ext_en <= ext_tick;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_osc_run <= 1'b1;
        end else begin
            int_osc_run <= int_ctrl[scs_pkg::BIT_INT_ON];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xosc_mode <= 3'h0;
            xosc_range <= 3'h0;
        end else begin
            xosc_mode <= ext_ctrl[6:4];
            xosc_range <= ext_ctrl[2:0];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            if (bus.addr == scs_pkg::ADDR_INT_CTRL) begin
                rdata <= {int_ctrl[7], int_rdy, 4'h0, int_ctrl[1:0]};
            end else if (bus.addr == scs_pkg::ADDR_INT_CAL) begin
                rdata <= int_cal;
            end else if (bus.addr == scs_pkg::ADDR_EXT_CTRL) begin
                rdata <= {xtal_valid, ext_ctrl[6:4], 1'b0, ext_ctrl[2:0]};
            end else if (bus.addr == scs_pkg::ADDR_CLK_SEL) begin
                rdata <= {7'h00, src_bit};
            end else begin
                rdata <= 8'h00;
            end
        end
    end
endmodule

// [testbench/scs_ext_osc.sv]
/* external clock source model.
   assumes its mode input comes from the block's mode field. */
`timescale 1ns/1ps
module scs_ext_osc #(
    parameter int PER = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] mode,
    output logic tick
);
    int n;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n || mode[2:1] == 2'b00) begin
            n <= 0;
            tick <= #1 1'b0;
        end else begin
            n <= (n + 1) % PER;
            tick <= #1 (n == PER - 1);
        end
    end
endmodule

// [testbench/scs_properties.sv]
/* port checker for the clock source block.
   assumes one clock domain, reset active low. */
`timescale 1ns/1ps
module scs_top_checker #(
    parameter int XTAL_SETTLE = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire scs_pkg::scs_bus_s bus,
    input wire logic [7:0] rdata,
    input wire logic int_osc_tick,
    input wire logic ext_osc_tick,
    input wire logic sysclk_en,
    input wire logic periph_ext_en,
    input wire logic int_osc_run,
    input wire logic [2:0] xosc_mode,
    input wire logic [2:0] xosc_range
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire wr = bus.sel && bus.wr;
    wire rd = bus.sel && !bus.wr;
    int_enable_a: assert property (wr && bus.addr == 8'h8A |-> ##2
        int_osc_run == $past(bus.wdata[7], 2))
        else $error("enable bit mismatch");
    mode_field_a: assert property (wr && bus.addr == 8'h8C |-> ##2
        xosc_mode == $past(bus.wdata[6:4], 2))
        else $error("mode field mismatch");
    range_field_a: assert property (wr && bus.addr == 8'h8C |-> ##2
        xosc_range == $past(bus.wdata[2:0], 2))
        else $error("range field mismatch");
    ext_rsvd_a: assert property (rd && bus.addr == 8'h8C |=> !rdata[3])
        else $error("reserved bit set");
    valid_off_a: assert property (rd && bus.addr == 8'h8C && xosc_mode[2:1] != 2'b11
        |=> !rdata[7])
        else $error("valid flag outside crystal mode");
    sel_rsvd_a: assert property (rd && bus.addr == 8'h8D |=> rdata[7:1] == 7'h00)
        else $error("select reserved bits set");
    cal_rw_a: assert property ((wr && bus.addr == 8'h8B) ##2 (rd && bus.addr == 8'h8B)
        |=> rdata == $past(bus.wdata, 3))
        else $error("calibration readback mismatch");
    ext_idle_a: assert property (xosc_mode[2:1] == 2'b00 && $past(xosc_mode[2:1]) == 2'b00
        |-> !periph_ext_en)
        else $error("external enable while off");
    periph_src_a: assert property (periph_ext_en
        |-> $past(ext_osc_tick) || $past(ext_osc_tick, 2))
        else $error("peripheral enable without tick");
    sys_src_a: assert property (sysclk_en
        |-> $past(int_osc_tick) || $past(int_osc_tick, 2) || $past(ext_osc_tick)
        || $past(ext_osc_tick, 2))
        else $error("system enable without tick");
    rdy_off_a: assert property (rd && bus.addr == 8'h8A && !int_osc_run |=> !rdata[6])
        else $error("ready flag while disabled");
endmodule
bind scs_top scs_top_checker #(.XTAL_SETTLE(XTAL_SETTLE)) chk_u (.clk(clk), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .int_osc_tick(int_osc_tick), .ext_osc_tick(ext_osc_tick), .sysclk_en(sysclk_en),
    .periph_ext_en(periph_ext_en), .int_osc_run(int_osc_run), .xosc_mode(xosc_mode),
    .xosc_range(xosc_range));

// [testbench/scs_top_tb_top.sv]
/* self-checking bench for the clock source block.
   assumes the external source model and the checker bind. */
`timescale 1ns/1ps
`define CHK(a, b, m) begin \
    total_checks++; \
    if ((a) !== (b)) begin \
        n_mismatch++; \
        $display("CHECK FAILED %0t %s", $time, m); \
    end \
end
module scs_top_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic int_tick = 1'b0;
    logic ext_tick, sysclk_en, periph_ext_en, int_osc_run;
    scs_pkg::scs_bus_s bus = '0;
    logic [7:0] rdata, r;
    logic [2:0] xosc_mode, xosc_range;
    logic [7:0] exp_q[$];
    logic rd_d = 1'b0;
    logic [31:0] seed = 32'h05CC;
    int n_mismatch = 0;
    int total_checks = 0;
    integer ns, np;
    always #5 clk = ~clk;
    // internal osc: one tick every other cycle while enabled
    always @(posedge clk) int_tick <= #1 (int_osc_run === 1'b1) && !int_tick;
    scs_top #(.XTAL_SETTLE(8)) dut_u (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .int_osc_tick(int_tick), .ext_osc_tick(ext_tick), .sysclk_en(sysclk_en),
        .periph_ext_en(periph_ext_en), .int_osc_run(int_osc_run), .xosc_mode(xosc_mode),
        .xosc_range(xosc_range));
    scs_ext_osc #(.PER(2)) osc_u (.clk(clk), .rst_n(rst_n), .mode(xosc_mode), .tick(ext_tick));
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    always @(posedge clk) begin
        if (rd_d) `CHK(rdata, exp_q.pop_front(), "read data")
        rd_d <= bus.sel & ~bus.wr;
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        bus = '{sel: 1'b1, wr: w, addr: a, wdata: d};
        if (!w) exp_q.push_back(d);
        @(posedge clk);
        #1;
        bus.sel = 1'b0;
    endtask
    task automatic cnt(input int n);
        ns = 0;
        np = 0;
        repeat (8) @(posedge clk);
        repeat (n) begin
            @(negedge clk);
            ns += sysclk_en;
            np += periph_ext_en;
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #300us;
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        acc(0, 8'h8A, 8'hC0);
        acc(0, 8'h8D, 8'h00);
        acc(0, 8'h8B, scs_pkg::RST_INT_CAL);
        `CHK(int_osc_run, 1'b1, "enable at reset")
        for (int c = 0; c < 4; c++) begin
            acc(1, 8'h8A, 8'h80 | c[7:0]);
            cnt(64);
            `CHK(ns, 4 << c, "prescale count")
        end
        acc(1, 8'h8A, 8'h43);
        acc(0, 8'h8A, 8'h03);
        `CHK(int_osc_run, 1'b0, "enable off")
        acc(1, 8'h8A, 8'h83);
        acc(0, 8'h8A, 8'h83);
        repeat (12) @(posedge clk);
        acc(0, 8'h8A, 8'hC3);
        r = rnd();
        acc(1, 8'h8B, r);
        acc(0, 8'h8B, r);
        for (int m = 0; m < 8; m++) begin
            r = rnd();
            acc(1, 8'h8C, {1'b1, m[2:0], 1'b1, r[2:0]});
            cnt(32);
            `CHK({xosc_mode, xosc_range}, {m[2:0], r[2:0]}, "ext fields")
            `CHK(np, m < 2 ? 0 : (m == 2 || m == 6) ? 16 : 8, "ext count")
            acc(0, 8'h8C, {m > 5, m[2:0], 1'b0, r[2:0]});
        end
        acc(1, 8'h8D, 8'hFF);
        cnt(32);
        `CHK(ns, 8, "external sysclk count")
        acc(0, 8'h8D, 8'h01);
        acc(0, 8'h90, 8'h00);
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        acc(0, 8'h8D, 8'h00);
        `CHK({int_osc_run, xosc_mode, xosc_range}, 7'h40, "outputs after reset")
        acc(0, 8'h8A, 8'hC0);
        cnt(64);
        `CHK(ns, 4, "sysclk after reset")
        `CHK(np, 0, "ext idle after reset")
        `CHK(exp_q.size(), 0, "reads pending")
        test_done();
    end
endmodule
